// ==== sc_serial_ctrl.sv ====
// Per-channel serial control and monitor streams with APB registers.
// Assumes bit clock and frame sync pins far slower than pclk.
//
// The address map and the APB slave port were decided locally.
module sc_serial_ctrl
  import sc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ser_clk_in,
  input wire logic frame_sync_in,
  input wire logic channel_bypass_in,
  input wire logic residual_suppress_off_in,
  input wire logic hold_in,
  input wire logic law_convert_off_in,
  input wire logic clear_channel_in,
  input wire logic flexible_control_in,
  input sc_events_t events,
  output sc_chan_ctrl_t chan_ctrl,
  output logic bypass_state_out,
  output logic suppress_off_state_out,
  output logic hold_state_out,
  output logic coeff_clear_state_out,
  output logic law_convert_off_state_out,
  output logic clear_channel_state_out,
  output logic event_monitor_a_out,
  output logic event_monitor_b_out
);
  logic [7:0] pins_sync;
  logic [SC_IN_NUM-1:0] in_bits;
  logic ser_clk_s;
  logic fsync_s;
  logic ser_clk_prev_reg;
  logic ser_clk_prev_next;
  logic bit_edge;
  logic [SC_SLOT_W-1:0] slot_reg;
  logic [SC_SLOT_W-1:0] slot_next;
  logic [SC_SLOT_W-1:0] cur_slot;
  logic framed_reg;
  logic framed_next;
  logic [SC_CHANNELS-1:0] raw_reg [SC_IN_NUM];
  logic [SC_CHANNELS-1:0] raw_next [SC_IN_NUM];
  logic [SC_MASK_W-1:0] mask_reg;
  logic [SC_MASK_W-1:0] mask_next;
  logic [SC_FLEX_W-1:0] flex_reg;
  logic [SC_FLEX_W-1:0] flex_next;
  logic [7:0] evsel_reg;
  logic [7:0] evsel_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  sc_chan_ctrl_t ctrl_reg;
  sc_chan_ctrl_t ctrl_next;
  sc_mon_t mon_reg;
  sc_mon_t mon_next;
  logic [SC_CHANNELS-1:0] req [SC_IN_NUM];
  logic [SC_CHANNELS-1:0] ev_a;
  logic [SC_CHANNELS-1:0] ev_b;
  sc_flex_t flex_act;
  logic access;
  logic known;

  // Pins are asynchronous to pclk
  sc_sync #(
    .WIDTH(8)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({ser_clk_in, frame_sync_in, flexible_control_in, clear_channel_in,
          law_convert_off_in, hold_in, residual_suppress_off_in, channel_bypass_in}),
    .level(pins_sync)
  );

  assign in_bits = pins_sync[5:0];
  assign fsync_s = pins_sync[6];
  assign ser_clk_s = pins_sync[7];
  assign bit_edge = ser_clk_s & ~ser_clk_prev_reg;
  assign flex_act = sc_flex_t'(flex_reg);

  sc_event_sel u_sel_a (
    .events(events),
    .code(evsel_reg[SC_EVA_LSB +: 4]),
    .chosen(ev_a)
  );

  sc_event_sel u_sel_b (
    .events(events),
    .code(evsel_reg[SC_EVB_LSB +: 4]),
    .chosen(ev_b)
  );

  // Slot timing: the edge with frame sync high is slot 0
  always_comb begin
    ser_clk_prev_next = ser_clk_s;
    cur_slot = fsync_s ? '0 : slot_reg;
    slot_next = slot_reg;
    framed_next = framed_reg;
    if (bit_edge) begin
      slot_next = cur_slot + 5'd1;
      if (fsync_s) begin
        framed_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_clk_prev_reg <= 1'b0;
      slot_reg <= '0;
      framed_reg <= 1'b0;
    end else begin
      ser_clk_prev_reg <= ser_clk_prev_next;
      slot_reg <= slot_next;
      framed_reg <= framed_next;
    end
  end

  // Each stream bit lands in its channel's position
  always_comb begin
    for (int s = 0; s < SC_IN_NUM; s++) begin
      raw_next[s] = raw_reg[s];
      req[s] = mask_reg[s] ? '0 : raw_reg[s];
      if (bit_edge) begin
        raw_next[s][cur_slot] = in_bits[s];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < SC_IN_NUM; s++) begin
        raw_reg[s] <= '0;
      end
    end else begin
      for (int s = 0; s < SC_IN_NUM; s++) begin
        raw_reg[s] <= raw_next[s];
      end
    end
  end

  // Effective channel state handed to the core
  always_comb begin
    logic [SC_CHANNELS-1:0] fx;
    fx = req[SC_IN_FLEX];
    ctrl_next.bypass = req[SC_IN_BYP] | req[SC_IN_CLR];
    ctrl_next.suppress_off = req[SC_IN_SUPP];
    ctrl_next.hold = req[SC_IN_HOLD];
    ctrl_next.law_off = req[SC_IN_LAW] | req[SC_IN_CLR];
    ctrl_next.coeff_clear = '0;
    case (flex_act)
      SC_FLEX_BYPASS: ctrl_next.bypass = ctrl_next.bypass | fx;
      SC_FLEX_SUPP_OFF: ctrl_next.suppress_off = ctrl_next.suppress_off | fx;
      SC_FLEX_HOLD: ctrl_next.hold = ctrl_next.hold | fx;
      SC_FLEX_LAW_OFF: ctrl_next.law_off = ctrl_next.law_off | fx;
      SC_FLEX_CLEAR_CH: begin
        ctrl_next.bypass = ctrl_next.bypass | fx;
        ctrl_next.law_off = ctrl_next.law_off | fx;
      end
      SC_FLEX_COEF_CLR: ctrl_next.coeff_clear = fx;
      default: ctrl_next.coeff_clear = '0;
    endcase
    ctrl_next.suppress_off = ctrl_next.suppress_off | ctrl_next.bypass;
    ctrl_next.coeff_clear = ctrl_next.coeff_clear | ctrl_next.bypass;
    ctrl_next.hold = ctrl_next.hold & ~ctrl_next.coeff_clear;
    ctrl_next.law_off = ctrl_next.law_off;
  end

  // Monitor bits change only on the serial bit edge
  always_comb begin
    mon_next = mon_reg;
    if (bit_edge) begin
      mon_next.bypass = ctrl_reg.bypass[cur_slot];
      mon_next.suppress_off = ctrl_reg.suppress_off[cur_slot];
      mon_next.hold = ctrl_reg.hold[cur_slot];
      mon_next.coeff_clear = ctrl_reg.coeff_clear[cur_slot];
      mon_next.law_off = ctrl_reg.law_off[cur_slot];
      mon_next.clear_ch = ctrl_reg.bypass[cur_slot] & ctrl_reg.law_off[cur_slot];
      mon_next.event_a = ev_a[cur_slot];
      mon_next.event_b = ev_b[cur_slot];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      mon_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      mon_reg <= mon_next;
    end
  end

  // APB slave with one wait state
  always_comb begin
    access = psel & penable & ~pready_reg;
    known = 1'b1;
    mask_next = mask_reg;
    flex_next = flex_reg;
    evsel_next = evsel_reg;
    prdata_next = prdata_reg;
    pready_next = access;
    pslverr_next = 1'b0;
    case (paddr)
      SC_CTRL_ADDR: prdata_next = {21'h0, flex_reg, 2'h0, mask_reg};
      SC_EVSEL_ADDR: prdata_next = {24'h0, evsel_reg};
      SC_STATUS_ADDR: prdata_next = {26'h0, framed_reg, slot_reg};
      SC_BYP_ADDR: prdata_next = ctrl_reg.bypass;
      SC_SUPP_ADDR: prdata_next = ctrl_reg.suppress_off;
      SC_HOLD_ADDR: prdata_next = ctrl_reg.hold;
      SC_LAW_ADDR: prdata_next = ctrl_reg.law_off;
      default: begin
        prdata_next = '0;
        known = 1'b0;
      end
    endcase
    if (!access || pwrite) begin
      prdata_next = '0;
    end
    if (access) begin
      pslverr_next = ~known;
      if (pwrite && paddr == SC_CTRL_ADDR) begin
        mask_next = pwdata[SC_MASK_LSB +: SC_MASK_W];
        flex_next = pwdata[SC_FLEX_LSB +: SC_FLEX_W];
      end
      if (pwrite && paddr == SC_EVSEL_ADDR) begin
        evsel_next = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= SC_MASK_RST;
      flex_reg <= SC_FLEX_RST;
      evsel_reg <= SC_EVSEL_RST;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      flex_reg <= flex_next;
      evsel_reg <= evsel_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign chan_ctrl = ctrl_reg;
  assign bypass_state_out = mon_reg.bypass;
  assign suppress_off_state_out = mon_reg.suppress_off;
  assign hold_state_out = mon_reg.hold;
  assign coeff_clear_state_out = mon_reg.coeff_clear;
  assign law_convert_off_state_out = mon_reg.law_off;
  assign clear_channel_state_out = mon_reg.clear_ch;
  assign event_monitor_a_out = mon_reg.event_a;
  assign event_monitor_b_out = mon_reg.event_b;
endmodule

// ==== sc_pkg.sv ====
// Shared constants and types of the per-channel serial control block.
// Assumes a 32-bit APB master and a canceller core on the same clock.
package sc_pkg;
  localparam int SC_CHANNELS = 32;
  localparam int SC_SLOT_W = 5;

  // Register byte offsets
  localparam logic [7:0] SC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] SC_EVSEL_ADDR = 8'h04;
  localparam logic [7:0] SC_STATUS_ADDR = 8'h08;
  localparam logic [7:0] SC_BYP_ADDR = 8'h0c;
  localparam logic [7:0] SC_SUPP_ADDR = 8'h10;
  localparam logic [7:0] SC_HOLD_ADDR = 8'h14;
  localparam logic [7:0] SC_LAW_ADDR = 8'h18;

  // Control, event select and status register fields
  localparam int SC_MASK_LSB = 0;
  localparam int SC_MASK_W = 6;
  localparam int SC_FLEX_LSB = 8;
  localparam int SC_FLEX_W = 3;
  localparam logic [5:0] SC_MASK_RST = 6'h00;
  localparam logic [2:0] SC_FLEX_RST = 3'h0;
  localparam logic [7:0] SC_EVSEL_RST = 8'h00;
  localparam int SC_EVA_LSB = 4;
  localparam int SC_EVB_LSB = 0;
  localparam int SC_FRAME_BIT = 5;

  // Input stream order inside the mask and the stream vector
  localparam int SC_IN_BYP = 0;
  localparam int SC_IN_SUPP = 1;
  localparam int SC_IN_HOLD = 2;
  localparam int SC_IN_LAW = 3;
  localparam int SC_IN_CLR = 4;
  localparam int SC_IN_FLEX = 5;
  localparam int SC_IN_NUM = 6;

  typedef enum logic [2:0] {
    SC_FLEX_NONE = 3'b000,
    SC_FLEX_BYPASS = 3'b001,
    SC_FLEX_SUPP_OFF = 3'b010,
    SC_FLEX_HOLD = 3'b011,
    SC_FLEX_LAW_OFF = 3'b100,
    SC_FLEX_CLEAR_CH = 3'b101,
    SC_FLEX_COEF_CLR = 3'b110
  } sc_flex_t;

  typedef enum logic [3:0] {
    SC_EV_NONE = 4'h0,
    SC_EV_IDLE = 4'h1,
    SC_EV_T2010 = 4'h2,
    SC_EV_T2100 = 4'h3,
    SC_EV_T2100_PR = 4'h4,
    SC_EV_T2100_ANY = 4'h5,
    SC_EV_DTALK = 4'h6,
    SC_EV_NO_SPEECH = 4'h7
  } sc_event_t;

  // Per-channel detector flags from the core
  typedef struct packed {
    logic [31:0] idle;
    logic [31:0] tone2010;
    logic [31:0] tone2100;
    logic [31:0] tone2100_pr;
    logic [31:0] double_talk;
    logic [31:0] no_speech;
  } sc_events_t;

  // Per-channel processing state sent to the core
  typedef struct packed {
    logic [31:0] bypass;
    logic [31:0] suppress_off;
    logic [31:0] hold;
    logic [31:0] coeff_clear;
    logic [31:0] law_off;
  } sc_chan_ctrl_t;

  // Monitor pins, one bit each
  typedef struct packed {
    logic bypass;
    logic suppress_off;
    logic hold;
    logic coeff_clear;
    logic law_off;
    logic clear_ch;
    logic event_a;
    logic event_b;
  } sc_mon_t;
endpackage

// ==== sc_sync.sv ====
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the pins are slow against pclk; no bundle coherency.
module sc_sync
  import sc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  always_comb begin
    meta_next = pin;
    level_next = meta_reg;
  end

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      level_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule

// ==== sc_event_sel.sv ====
// Selects one per-channel detector vector, or for code 5 the OR of tone2100 and tone2100_pr, by a 4-bit code.
// Pure logic; the caller registers the chosen bit.
module sc_event_sel
  import sc_pkg::*;
(
  input sc_events_t events,
  input wire logic [3:0] code,
  output logic [SC_CHANNELS-1:0] chosen
);
  always_comb begin
    case (sc_event_t'(code))
      SC_EV_IDLE: chosen = events.idle;
      SC_EV_T2010: chosen = events.tone2010;
      SC_EV_T2100: chosen = events.tone2100;
      SC_EV_T2100_PR: chosen = events.tone2100_pr;
      SC_EV_T2100_ANY: chosen = events.tone2100 | events.tone2100_pr;
      SC_EV_DTALK: chosen = events.double_talk;
      SC_EV_NO_SPEECH: chosen = events.no_speech;
      default: chosen = '0;
    endcase
  end
endmodule

// ==== sc_serial_ctrl_properties.sv ====
// Port checker of the serial control block.
// Assumes a bind from the bench; one pclk domain.
module sc_serial_ctrl_properties
  import sc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ser_clk_in,
  input sc_chan_ctrl_t chan_ctrl,
  input wire logic bypass_state_out,
  input wire logic suppress_off_state_out,
  input wire logic hold_state_out,
  input wire logic coeff_clear_state_out,
  input wire logic law_convert_off_state_out,
  input wire logic clear_channel_state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_APB_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_CLEAR_MON: assert property (
    clear_channel_state_out == (bypass_state_out && law_convert_off_state_out))
    else $error("clear monitor mismatch");
  AST_BYP_MON: assert property (
    bypass_state_out |-> suppress_off_state_out && coeff_clear_state_out)
    else $error("bypass monitor inconsistent");
  AST_HOLD_MON: assert property (hold_state_out |-> !coeff_clear_state_out)
    else $error("hold shown while clearing");
  AST_CHAN_BYP: assert property ((chan_ctrl.bypass & ~chan_ctrl.coeff_clear) == 32'h0)
    else $error("bypass without coefficient clear");
  // Monitors move only after a bit edge
  AST_MON_EDGE: assert property (
    !$stable({bypass_state_out, hold_state_out, law_convert_off_state_out})
    |-> $past(ser_clk_in, 2) || $past(ser_clk_in, 3) || $past(ser_clk_in, 4))
    else $error("monitor changed off a bit edge");
  cover property (pslverr);
  cover property (clear_channel_state_out);
  cover property (hold_state_out);
endmodule

// ==== sc_ctl_model.sv ====
// External control logic: sends one frame, samples monitors.
// Assumes pulled-down pins, so all rest low between frames.
module sc_ctl_model
  import sc_pkg::*;
#(
  parameter int HALF = 10
) (
  input wire logic pclk,
  input wire logic go,
  input wire logic [5:0][31:0] bits,
  input sc_mon_t mon,
  output logic busy,
  output logic ser_clk,
  output logic fsync,
  output logic [5:0] data,
  output logic [7:0][31:0] cap
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    busy = 1'b0;
    ser_clk = 1'b0;
    fsync = 1'b0;
    data = 6'h00;
    cap = '0;
  end
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      for (int n = 0; n < SC_CHANNELS; n++) begin
        fsync <= (n == 0);
        for (int s = 0; s < SC_IN_NUM; s++) data[s] <= bits[s][n];
        repeat (HALF) @(posedge pclk);
        ser_clk <= 1'b1;
        repeat (HALF) @(posedge pclk);
        ser_clk <= 1'b0;
        for (int m = 0; m < 8; m++) cap[m][n] <= mon[m];
      end
      fsync <= 1'b0;
      data <= 6'h00;
      busy <= 1'b0;
    end
  end
endmodule

// ==== sc_serial_ctrl_bench.sv ====
// Bench: APB tasks, frames from the control model, checks.
// Assumes the model bit clock is far slower than pclk.
module sc_serial_ctrl_bench
  import sc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ser_clk, fsync, busy, go = 1'b0;
  logic [5:0] sdata;
  logic [5:0][31:0] bits;
  logic [7:0][31:0] cap;
  sc_events_t events;
  sc_chan_ctrl_t chan_ctrl;
  wire sc_mon_t mon;
  int errors = 0;
  int comparisons = 0;
  always #5 pclk = ~pclk;
  sc_serial_ctrl sc_serial_ctrl_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ser_clk_in(ser_clk), .frame_sync_in(fsync), .channel_bypass_in(sdata[0]),
    .residual_suppress_off_in(sdata[1]), .hold_in(sdata[2]), .law_convert_off_in(sdata[3]),
    .clear_channel_in(sdata[4]), .flexible_control_in(sdata[5]), .events, .chan_ctrl,
    .bypass_state_out(mon.bypass), .suppress_off_state_out(mon.suppress_off),
    .hold_state_out(mon.hold), .coeff_clear_state_out(mon.coeff_clear),
    .law_convert_off_state_out(mon.law_off), .clear_channel_state_out(mon.clear_ch),
    .event_monitor_a_out(mon.event_a), .event_monitor_b_out(mon.event_b));
  sc_ctl_model sc_ctl_model_inst (.pclk, .go, .bits, .mon, .busy, .ser_clk, .fsync,
    .data(sdata), .cap);
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait bounded; slow answers stay legal
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    // A missing answer ends the run as a failure
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic frame();
    int t = 0;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy !== 1'b0 && t < 1000) begin
      @(posedge pclk);
      t++;
    end
    if (busy !== 1'b0) begin
      errors++;
      stop_test();
    end
  endtask
  function automatic sc_chan_ctrl_t ctl(input logic [5:0] m, input logic [2:0] f);
    logic [5:0][31:0] s;
    logic [31:0] x;
    sc_chan_ctrl_t c;
    for (int i = 0; i < SC_IN_NUM; i++) s[i] = m[i] ? 32'h0 : bits[i];
    x = s[SC_IN_FLEX];
    c.bypass = s[0] | s[4] | (f == SC_FLEX_BYPASS || f == SC_FLEX_CLEAR_CH ? x : '0);
    c.law_off = s[3] | s[4] | (f == SC_FLEX_LAW_OFF || f == SC_FLEX_CLEAR_CH ? x : '0);
    c.suppress_off = s[1] | c.bypass | (f == SC_FLEX_SUPP_OFF ? x : '0);
    c.coeff_clear = c.bypass | (f == SC_FLEX_COEF_CLR ? x : '0);
    c.hold = (s[2] | (f == SC_FLEX_HOLD ? x : '0)) & ~c.coeff_clear;
    return c;
  endfunction
  function automatic logic [31:0] ev(input int k);
    case (k)
      1: return events.idle;
      2: return events.tone2010;
      3: return events.tone2100;
      4: return events.tone2100_pr;
      5: return events.tone2100 | events.tone2100_pr;
      6: return events.double_talk;
      7: return events.no_speech;
      default: return 32'h0;
    endcase
  endfunction
  // Second frame repeats the data, so monitors show it
  task automatic run(input logic [5:0] m, input logic [2:0] f);
    sc_chan_ctrl_t c;
    c = ctl(m, f);
    wr(SC_CTRL_ADDR, {21'h0, f, 2'h0, m});
    frame();
    frame();
    rd(SC_BYP_ADDR, c.bypass);
    rd(SC_SUPP_ADDR, c.suppress_off);
    rd(SC_HOLD_ADDR, c.hold);
    rd(SC_LAW_ADDR, c.law_off);
    rd(SC_STATUS_ADDR, 32'h1 << SC_FRAME_BIT);
    chk(chan_ctrl.coeff_clear, c.coeff_clear);
    chk(cap[7], c.bypass);
    chk(cap[6], c.suppress_off);
    chk(cap[5], c.hold);
    chk(cap[4], c.coeff_clear);
    chk(cap[3], c.law_off);
    chk(cap[2], c.bypass & c.law_off);
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    stop_test();
  end
  initial begin
    logic [31:0] q;
    logic e;
    events = {32'h0000_ff0f, 32'h0f0f_0f0f, 32'h3333_3333, 32'h5555_0000,
              32'h00ff_00ff, 32'h8421_8421};
    bits = {32'h0f00_00f0, 32'h8100_0001, 32'h000f_0000, 32'h0000_0f0f,
            32'h0000_00f0, 32'h0000_000f};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SC_CTRL_ADDR, 32'h0);
    rd(SC_EVSEL_ADDR, 32'h0);
    rd(SC_STATUS_ADDR, 32'h0);
    wr(SC_BYP_ADDR, 32'hffff_ffff);
    rd(SC_BYP_ADDR, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(SC_CTRL_ADDR, 32'h0000_053f);
    rd(SC_CTRL_ADDR, 32'h0000_053f);
    for (int f = 0; f < 7; f++) run(6'h00, f[2:0]);
    run(6'h15, 3'h0);
    run(6'h3f, 3'h5);
    for (int k = 0; k < 9; k++) begin
      wr(SC_EVSEL_ADDR, {24'h0, k[3:0], 4'(8 - k)});
      rd(SC_EVSEL_ADDR, {24'h0, k[3:0], 4'(8 - k)});
      frame();
      chk(cap[1], ev(k));
      chk(cap[0], ev(8 - k));
    end
    // Mid-run reset clears registers and stored bits
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SC_CTRL_ADDR, 32'h0);
    rd(SC_STATUS_ADDR, 32'h0);
    rd(SC_BYP_ADDR, 32'h0);
    stop_test();
  end
endmodule
bind sc_serial_ctrl sc_serial_ctrl_properties sc_serial_ctrl_properties_inst (.pclk,
  .presetn, .psel, .penable, .prdata, .pready, .pslverr, .ser_clk_in, .chan_ctrl,
  .bypass_state_out, .suppress_off_state_out, .hold_state_out, .coeff_clear_state_out,
  .law_convert_off_state_out, .clear_channel_state_out);
